/* design/dtf_consts.svh */
// Constants for the training FIFO link: timing, opcodes, register map
`ifndef DTF_CONSTS_SVH
`define DTF_CONSTS_SVH
// Clock and printed times in picoseconds; the minimum gap in clock cycles
`define DTF_TCK_PS 50000
`define DTF_T7P5_PS 7500
`define DTF_MIN_GAP_NCK 8
`define DTF_DQSCK_MAX_PS 3500
`define DTF_DQSS_MAX_PS 62500
`define DTF_RPST_PS 75000
`define DTF_ODTON_MIN_PS 1500
// Latencies and gaps in clock cycles; burst in beats, depth in entries, width in bits
`define DTF_RL 14
`define DTF_WL 8
`define DTF_BL 16
`define DTF_WTR_NCK 8
`define DTF_WPRE_NCK 2
`define DTF_TERMINATION_ON_LATENCY_NCK 6
`define DTF_FIFO_DEPTH 5
`define DTF_DQW 32
// Training operand codes
`define DTF_OP_RD_FIFO 7'h41
`define DTF_OP_RD_CAL 7'h43
`define DTF_OP_WR_FIFO 7'h47
`define DTF_OP_TRAIN_BIT 6
// Controller registers, byte offsets
`define DTF_REG_CMD 8'h00
`define DTF_REG_WDATA 8'h04
`define DTF_REG_STATUS 8'h08
`define DTF_REG_RDATA 8'h0C
`define DTF_REG_CFG 8'h10
// Status fields
`define DTF_ST_BUSY 0
`define DTF_ST_ERR_FORBID 1
`define DTF_ST_ERR_BUSY 2
`define DTF_GAP_FORBID 8'hFF
`endif

/* design/dtf_pkg.sv */
// Types shared by both ends of the training FIFO link
package dtf_pkg;
    typedef enum logic [3:0] {
        DTF_CMD_DES = 4'h0,
        DTF_CMD_WR = 4'h1,
        DTF_CMD_MWR = 4'h2,
        DTF_CMD_RD = 4'h3,
        DTF_CMD_MRR = 4'h4,
        DTF_CMD_MRW = 4'h5,
        DTF_CMD_MPC = 4'h6,
        DTF_CMD_CAS2 = 4'h7,
        DTF_CMD_REF = 4'h8,
        DTF_CMD_SRE = 4'h9,
        DTF_CMD_SRX = 4'hA
    } dtf_cmd_e;
    typedef enum logic [2:0] {
        DTF_K_WRF = 3'h0,
        DTF_K_RDF = 3'h1,
        DTF_K_CAL = 3'h2,
        DTF_K_WR = 3'h3,
        DTF_K_RD = 3'h4,
        DTF_K_MRW = 3'h5,
        DTF_K_NONE = 3'h7
    } dtf_kind_e;
    typedef enum logic [1:0] {
        DTF_C_IDLE = 2'h0,
        DTF_C_WAIT = 2'h1,
        DTF_C_CAS2 = 2'h2
    } dtf_cst_e;
endpackage

/* design/dtf_if.sv */
// Command and data link between controller and training DRAM
`timescale 1ns/100ps
interface dtf_if;
    import dtf_pkg::*;
    logic cke;
    dtf_cmd_e cmd;
    logic [6:0] op;
    logic [31:0] c_dq_out;
    logic c_dq_oe;
    logic [1:0] c_dmi_out;
    logic c_dmi_oe;
    logic [31:0] d_dq_out;
    logic d_dq_oe;
    logic [1:0] d_dmi_out;
    logic d_dmi_oe;
    logic [31:0] dq;
    logic [1:0] mask_inversion_pins;
    // Wire level resolved from the enables; idle bus reads low
    assign dq = c_dq_oe ? c_dq_out : (d_dq_oe ? d_dq_out : 32'h0);
    assign mask_inversion_pins = c_dmi_oe ? c_dmi_out : (d_dmi_oe ? d_dmi_out : 2'h0);
    modport ctrl (output cke, cmd, op, c_dq_out, c_dq_oe, c_dmi_out, c_dmi_oe,
        input dq, mask_inversion_pins);
    modport dram (input cke, cmd, op, dq, mask_inversion_pins,
        output d_dq_out, d_dq_oe, d_dmi_out, d_dmi_oe);
endinterface

/* design/dtf_dram.sv */
// Device end: training FIFO with command decode and read/write bursts
`timescale 1ns/100ps
`include "dtf_consts.svh"
module dtf_dram #(
    parameter int RL = `DTF_RL,
    parameter int WL = `DTF_WL,
    parameter int DEPTH = `DTF_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    dtf_if.dram lnk,
    input wire logic wr_inv_en,
    input wire logic rd_inv_en,
    input wire logic mask_en,
    output logic [2:0] fifo_wr_ptr,
    output logic [2:0] fifo_rd_ptr,
    output logic in_self_refresh
);
    import dtf_pkg::*;
    localparam int NB = `DTF_BL / 2;

    logic [31:0] mem [DEPTH][NB];
    logic [1:0] dmem [DEPTH][NB];
    logic [6:0] mpc_op;
    logic wr_go, rd_go, cal_go, disturb;
    logic [WL-1:0] wpipe;
    logic [RL-1:0] rpipe, cpipe;
    logic [2:0] wslot, rslot, wbeat, rbeat;
    logic wact, ract, rcal;

    function automatic logic [2:0] next_ptr(input logic [2:0] p);
        return (p == 3'(DEPTH - 1)) ? 3'h0 : p + 3'h1;
    endfunction

    // -------------------------------------------------
    // Command decode
    // -------------------------------------------------
    // Commands count only with clock enable high, self refresh included
    assign wr_go = lnk.cke && lnk.cmd == DTF_CMD_CAS2
        && mpc_op == `DTF_OP_WR_FIFO;
    assign rd_go = lnk.cke && lnk.cmd == DTF_CMD_CAS2
        && mpc_op == `DTF_OP_RD_FIFO;
    assign cal_go = lnk.cke && lnk.cmd == DTF_CMD_CAS2
        && mpc_op == `DTF_OP_RD_CAL;
    // Ordinary traffic, a calibration read or a dropped clock enable resets the pointers to zero
    assign disturb = !lnk.cke || cal_go || lnk.cmd inside {DTF_CMD_WR,
        DTF_CMD_MWR, DTF_CMD_RD, DTF_CMD_MRR};

    // Operand of the first half; cleared top bit is a no-op
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            mpc_op <= 7'h0;
        else if (lnk.cke && lnk.cmd == DTF_CMD_MPC && lnk.op[`DTF_OP_TRAIN_BIT])
            mpc_op <= lnk.op;
        else
            mpc_op <= 7'h0;
    end

    // Self refresh tracking, reported to the user side
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            in_self_refresh <= 1'b0;
        else if (lnk.cke && lnk.cmd == DTF_CMD_SRE)
            in_self_refresh <= 1'b1;
        else if (lnk.cke && lnk.cmd == DTF_CMD_SRX)
            in_self_refresh <= 1'b0;
    end

    // Latency pipes, same timing as ordinary read and write
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wpipe <= '0;
            rpipe <= '0;
            cpipe <= '0;
        end
        else
        begin
            wpipe <= {wpipe[WL-2:0], wr_go};
            rpipe <= {rpipe[RL-2:0], rd_go};
            cpipe <= {cpipe[RL-2:0], cal_go};
        end
    end

    // -------------------------------------------------
    // FIFO write: always eight beat pairs, mode register burst ignored
    // -------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fifo_wr_ptr <= 3'h0;
            wslot <= 3'h0;
            wbeat <= 3'h0;
            wact <= 1'b0;
        end
        else if (wpipe[WL-1])
        begin
            wslot <= fifo_wr_ptr;
            fifo_wr_ptr <= next_ptr(fifo_wr_ptr);
            wbeat <= 3'h1;
            wact <= 1'b1;
        end
        else
        begin
            if (wact)
            begin
                wbeat <= wbeat + 3'h1;
                wact <= wbeat != 3'h7;
            end
            if (disturb)
                fifo_wr_ptr <= 3'h0;
        end
    end

    // Storage; a sixth write lands on the first slot again
    always_ff @(posedge mclk)
    begin
        if (wpipe[WL-1])
        begin
            mem[fifo_wr_ptr][0] <= lnk.dq;
            dmem[fifo_wr_ptr][0] <= lnk.mask_inversion_pins;
        end
        else if (wact)
        begin
            mem[wslot][wbeat] <= lnk.dq;
            dmem[wslot][wbeat] <= lnk.mask_inversion_pins;
        end
    end

    // -------------------------------------------------
    // FIFO and calibration read bursts
    // -------------------------------------------------
    // Start wins over the end of the previous burst: seamless at column_to_column_delay
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fifo_rd_ptr <= 3'h0;
            rslot <= 3'h0;
            rbeat <= 3'h0;
            ract <= 1'b0;
            rcal <= 1'b0;
            lnk.d_dq_out <= 32'h0;
            lnk.d_dq_oe <= 1'b0;
            lnk.d_dmi_out <= 2'h0;
            lnk.d_dmi_oe <= 1'b0;
        end
        else if (rpipe[RL-2] || cpipe[RL-2])
        begin
            rcal <= cpipe[RL-2];
            rslot <= fifo_rd_ptr;
            if (rpipe[RL-2])
                fifo_rd_ptr <= next_ptr(fifo_rd_ptr);
            // Unwritten slots return whatever they last held
            lnk.d_dq_out <= cpipe[RL-2] ? 32'h0 : mem[fifo_rd_ptr][0];
            lnk.d_dmi_out <= cpipe[RL-2] ? 2'h0 : dmem[fifo_rd_ptr][0];
            lnk.d_dmi_oe <= rpipe[RL-2] && (wr_inv_en || rd_inv_en || mask_en);
            lnk.d_dq_oe <= 1'b1;
            rbeat <= 3'h1;
            ract <= 1'b1;
        end
        else if (ract)
        begin
            lnk.d_dq_out <= rcal ? 32'h0 : mem[rslot][rbeat];
            lnk.d_dmi_out <= rcal ? 2'h0 : dmem[rslot][rbeat];
            rbeat <= rbeat + 3'h1;
            ract <= rbeat != 3'h7;
        end
        else
        begin
            lnk.d_dq_oe <= 1'b0;
            lnk.d_dmi_oe <= 1'b0;
            if (disturb)
                fifo_rd_ptr <= 3'h0;
        end
    end
endmodule

/* design/dtf_ctrl.sv */
// Controller end: APB-driven issuer of training commands with spacing checks
// Functional notes
// - FIFO write allowed while banks active, refresh
// - FIFO read to ordinary read waits read_to_training_delay
// - FIFO reads repeat every column_to_column_delay seamlessly
// - FIFO read data uses ordinary read latency
// - Reads keep data; pointer wraps after five
// - Unwritten entries read back undefined data
// - Second column command carries all-low operands
// - Mask/inversion pins driven when any enabled
// - Write to FIFO write waits write_to_training_delay
// - read_to_training_delay formula from latency terms
// - Only mode register writes between FIFO write, read
// - read_to_write_gap without termination formula
// - read_to_write_gap with termination formula
// - Read to calibration waits read_to_training_delay
// - FIFO read after calibration is forbidden
// - FIFO commands always use sixteen-beat bursts
// - Five entries; sixth write overwrites first
// - Operand codes 41h, 43h, 47h; top bit clear no-op
// - Second column command follows immediately
`timescale 1ns/100ps
`include "dtf_consts.svh"
module dtf_ctrl #(
    parameter int RL = `DTF_RL,
    parameter int WL = `DTF_WL
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    dtf_if.ctrl lnk
);
    import dtf_pkg::*;

    // -------------------------------------------------
    // Spacing terms in whole cycles
    // -------------------------------------------------
    localparam int TCK = `DTF_TCK_PS;
    localparam int HB = `DTF_BL / 2;
    localparam int T7P5 = (`DTF_T7P5_PS + TCK - 1) / TCK;
    localparam int M8 = (T7P5 > `DTF_MIN_GAP_NCK) ? T7P5 : `DTF_MIN_GAP_NCK;
    localparam int DQSCK = (`DTF_DQSCK_MAX_PS + TCK - 1) / TCK;
    localparam int DQSS = (`DTF_DQSS_MAX_PS + TCK - 1) / TCK;
    localparam int RPST = `DTF_RPST_PS / TCK;
    localparam int ODTON = `DTF_ODTON_MIN_PS / TCK;
    localparam int WRWTR = WL + HB + DQSS + M8;
    localparam int RTRRD = RL + DQSCK + HB + RPST + M8;
    localparam int WF2RF = WL + DQSS + HB + `DTF_WTR_NCK;
    localparam int RTW_OFF = RL + DQSCK + HB - WL + `DTF_WPRE_NCK + RPST;
    localparam int RTW_ON = RL + DQSCK + HB + RPST - `DTF_TERMINATION_ON_LATENCY_NCK - ODTON + 1;

    logic [31:0] wdata, rdata;
    logic term_en, err_forbid, err_busy;
    dtf_cst_e state;
    dtf_kind_e req, last;
    logic [7:0] since, gap, issue_at;
    logic acc, wr_cmd, ready, wr_go, rd_go, train;
    logic [WL-1:0] wpipe;
    logic [RL:0] rpipe;
    logic [2:0] wbeat;
    logic wact;

    // Least spacing from the previous command kind to the next one
    function automatic logic [7:0] need_gap(input dtf_kind_e p, input dtf_kind_e n,
        input logic t);
        logic [7:0] g;
        g = 8'(HB);
        case (p)
            DTF_K_WR:
                g = (n == DTF_K_WRF) ? 8'(WRWTR) : (n == DTF_K_RDF) ? `DTF_GAP_FORBID
                    : (n == DTF_K_CAL) ? 8'(WF2RF) : 8'(HB);
            DTF_K_RD:
                g = (n == DTF_K_RDF) ? `DTF_GAP_FORBID
                    : (n inside {DTF_K_WRF, DTF_K_CAL}) ? 8'(RTRRD) : 8'(HB);
            DTF_K_WRF:
                g = (n == DTF_K_WRF) ? 8'(HB) : (n == DTF_K_RDF) ? 8'(WF2RF)
                    : `DTF_GAP_FORBID;
            DTF_K_RDF:
                g = (n == DTF_K_RDF) ? 8'(HB) : (n == DTF_K_WRF)
                    ? (t ? 8'(RTW_ON) : 8'(RTW_OFF)) : 8'(RTRRD);
            DTF_K_CAL:
                g = (n == DTF_K_RDF) ? `DTF_GAP_FORBID
                    : (n == DTF_K_CAL) ? 8'(HB) : 8'(RTRRD);
            default:
                g = 8'h2;
        endcase
        if (n == DTF_K_MRW)
            g = 8'h1;
        return g;
    endfunction

    // Burst beat data derived from the write data register
    function automatic logic [31:0] beat_word(input logic [31:0] d, input logic [2:0] i);
        return d ^ {29'h0, i};
    endfunction

    // -------------------------------------------------
    // APB slave, one wait state
    // -------------------------------------------------
    assign acc = psel && penable && pready;
    assign wr_cmd = acc && pwrite && paddr == `DTF_REG_CMD;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !(paddr inside {`DTF_REG_CMD,
                `DTF_REG_WDATA, `DTF_REG_STATUS, `DTF_REG_RDATA, `DTF_REG_CFG});
            case (paddr)
                `DTF_REG_CMD: prdata <= {29'h0, req};
                `DTF_REG_WDATA: prdata <= wdata;
                `DTF_REG_STATUS: prdata <= {25'h0, last, 1'b0, err_busy, err_forbid,
                    state != DTF_C_IDLE};
                `DTF_REG_RDATA: prdata <= rdata;
                `DTF_REG_CFG: prdata <= {31'h0, term_en};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Configuration and sticky errors; a new error beats the clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdata <= 32'h0;
            term_en <= 1'b0;
            err_forbid <= 1'b0;
            err_busy <= 1'b0;
        end
        else
        begin
            if (acc && pwrite && paddr == `DTF_REG_WDATA)
                wdata <= pwdata;
            if (acc && pwrite && paddr == `DTF_REG_CFG)
                term_en <= pwdata[0];
            if (wr_cmd && state != DTF_C_IDLE)
                err_busy <= 1'b1;
            else if (acc && pwrite && paddr == `DTF_REG_STATUS && pwdata[`DTF_ST_ERR_BUSY])
                err_busy <= 1'b0;
            if (wr_cmd && state == DTF_C_IDLE
                && need_gap(last, dtf_kind_e'(pwdata[2:0]), term_en) == `DTF_GAP_FORBID)
                err_forbid <= 1'b1;
            else if (acc && pwrite && paddr == `DTF_REG_STATUS
                && pwdata[`DTF_ST_ERR_FORBID])
                err_forbid <= 1'b0;
        end
    end

    // -------------------------------------------------
    // Command issue
    // -------------------------------------------------
    assign train = req inside {DTF_K_WRF, DTF_K_RDF, DTF_K_CAL};
    assign gap = need_gap(last, req, term_en);
    // Paired command starts one cycle early so its second half lands on time
    assign issue_at = gap - (train ? 8'h2 : 8'h1);
    assign ready = state == DTF_C_WAIT && since >= issue_at;
    assign wr_go = (state == DTF_C_CAS2 && req == DTF_K_WRF)
        || (ready && req == DTF_K_WR);
    assign rd_go = state == DTF_C_CAS2 && req inside {DTF_K_RDF, DTF_K_CAL};

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= DTF_C_IDLE;
            req <= DTF_K_NONE;
            last <= DTF_K_NONE;
            since <= 8'hFF;
            lnk.cmd <= DTF_CMD_DES;
            lnk.op <= 7'h0;
            lnk.cke <= 1'b0;
        end
        else
        begin
            lnk.cke <= 1'b1;
            lnk.cmd <= DTF_CMD_DES;
            lnk.op <= 7'h0;
            if (since != 8'hFF)
                since <= since + 8'h1;
            case (state)
                DTF_C_IDLE:
                    if (wr_cmd && need_gap(last, dtf_kind_e'(pwdata[2:0]), term_en)
                        != `DTF_GAP_FORBID && pwdata[2:0] <= 3'h5)
                    begin
                        req <= dtf_kind_e'(pwdata[2:0]);
                        state <= DTF_C_WAIT;
                    end
                DTF_C_WAIT:
                    if (ready)
                    begin
                        case (req)
                            DTF_K_WRF: lnk.op <= `DTF_OP_WR_FIFO;
                            DTF_K_RDF: lnk.op <= `DTF_OP_RD_FIFO;
                            DTF_K_CAL: lnk.op <= `DTF_OP_RD_CAL;
                            DTF_K_MRW: lnk.op <= wdata[6:0];
                            default: lnk.op <= 7'h0;
                        endcase
                        case (req)
                            DTF_K_WR: lnk.cmd <= DTF_CMD_WR;
                            DTF_K_RD: lnk.cmd <= DTF_CMD_RD;
                            DTF_K_MRW: lnk.cmd <= DTF_CMD_MRW;
                            default: lnk.cmd <= DTF_CMD_MPC;
                        endcase
                        state <= train ? DTF_C_CAS2 : DTF_C_IDLE;
                        if (!train)
                            since <= 8'h0;
                        if (!train && req != DTF_K_MRW)
                            last <= req;
                    end
                DTF_C_CAS2:
                begin
                    lnk.cmd <= DTF_CMD_CAS2;
                    lnk.op <= 7'h0;
                    since <= 8'h0;
                    last <= req;
                    state <= DTF_C_IDLE;
                end
                default:
                    state <= DTF_C_IDLE;
            endcase
        end
    end

    // -------------------------------------------------
    // Write data drive and read capture
    // -------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wpipe <= '0;
            rpipe <= '0;
            wbeat <= 3'h0;
            wact <= 1'b0;
            rdata <= 32'h0;
            lnk.c_dq_out <= 32'h0;
            lnk.c_dq_oe <= 1'b0;
            lnk.c_dmi_out <= 2'h0;
            lnk.c_dmi_oe <= 1'b0;
        end
        else
        begin
            wpipe <= {wpipe[WL-2:0], wr_go};
            rpipe <= {rpipe[RL-1:0], rd_go};
            if (rpipe[RL])
                rdata <= lnk.dq;
            if (wpipe[WL-1])
            begin
                lnk.c_dq_out <= beat_word(wdata, 3'h0);
                lnk.c_dq_oe <= 1'b1;
                lnk.c_dmi_oe <= 1'b1;
                wbeat <= 3'h1;
                wact <= 1'b1;
            end
            else if (wact)
            begin
                lnk.c_dq_out <= beat_word(wdata, wbeat);
                wbeat <= wbeat + 3'h1;
                wact <= wbeat != 3'h7;
            end
            else
            begin
                lnk.c_dq_oe <= 1'b0;
                lnk.c_dmi_oe <= 1'b0;
            end
        end
    end
endmodule

/* tb/dtf_sva.sv */
// Checker for command order and data windows on the training FIFO link
`timescale 1ns/100ps
`include "dtf_consts.svh"
module dtf_sva #(
    parameter int RL = `DTF_RL
) (
    input wire logic mclk,
    input wire logic rst_n,
    input dtf_pkg::dtf_cmd_e cmd,
    input wire logic [6:0] op,
    input wire logic d_dq_oe,
    input wire logic d_dmi_oe
);
    import dtf_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic last_cal;
    logic open_wrf;
    logic rdf_pend;
    logic [5:0] since_rdf;
    // ----------------------------------------
    // Order tracking
    // ----------------------------------------
    // Mode register writes leave the last training kind alone
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_cal <= 1'b0;
            open_wrf <= 1'b0;
        end
        else if (cmd == DTF_CMD_MPC)
        begin
            last_cal <= op == `DTF_OP_RD_CAL;
            open_wrf <= op == `DTF_OP_WR_FIFO;
        end
        else if (cmd inside {DTF_CMD_WR, DTF_CMD_MWR, DTF_CMD_RD, DTF_CMD_MRR})
        begin
            last_cal <= 1'b0;
            open_wrf <= 1'b0;
        end
    end
    // Cycles since a FIFO read's second half, saturating
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdf_pend <= 1'b0;
            since_rdf <= 6'h3F;
        end
        else
        begin
            rdf_pend <= cmd == DTF_CMD_MPC && op == `DTF_OP_RD_FIFO;
            if (cmd == DTF_CMD_CAS2 && rdf_pend)
                since_rdf <= 6'h01;
            else if (since_rdf != 6'h3F)
                since_rdf <= since_rdf + 6'h01;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_cas2_after_mpc: assert property (cmd == DTF_CMD_MPC && op[6] |=> cmd == DTF_CMD_CAS2)
        else $error("second column command missing after training command");
    a_cas2_ops_low: assert property (cmd == DTF_CMD_CAS2 |-> op == 7'h00)
        else $error("second column command operands not low");
    a_rdf_latency: assert property (cmd == DTF_CMD_CAS2 && rdf_pend |-> ##RL d_dq_oe)
        else $error("FIFO read data not at read latency");
    a_burst_sixteen: assert property ($rose(d_dq_oe) |-> d_dq_oe [*8])
        else $error("read burst shorter than sixteen beats");
    a_dmi_in_window: assert property (d_dmi_oe |-> d_dq_oe)
        else $error("mask pins driven outside data window");
    a_no_rdf_after_cal: assert property (cmd == DTF_CMD_MPC && op == `DTF_OP_RD_FIFO |-> !last_cal)
        else $error("FIFO read issued after calibration read");
    a_ccd_spacing: assert property (cmd == DTF_CMD_CAS2 |=> cmd != DTF_CMD_CAS2 [*7])
        else $error("column commands closer than eight cycles");
    a_rtrrd_gap: assert property (cmd == DTF_CMD_RD |-> since_rdf >= 6'h20)
        else $error("read too soon after FIFO read");
    a_wrf_only_mrw: assert property (open_wrf |-> !(cmd inside {DTF_CMD_WR, DTF_CMD_MWR,
        DTF_CMD_RD, DTF_CMD_MRR}) && !(cmd == DTF_CMD_MPC && op == `DTF_OP_RD_CAL))
        else $error("command between FIFO write and FIFO read");
endmodule

/* tb/dram_training_fifo_cmd_timing_tb.sv */
// Testbench driving the controller over APB with the device end attached
`timescale 1ns/100ps
`include "dtf_consts.svh"
module dram_training_fifo_cmd_timing_tb;
    import dtf_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mask_en = 1'b1;
    logic seen_dmi = 1'b0;
    logic [2:0] fifo_wr_ptr;
    logic [2:0] fifo_rd_ptr;
    logic [31:0] r;
    logic rerr;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int cas_gap = 0;
    // Turn-around spacing from the rule terms, times rounded to whole cycles
    localparam int DQSCK_NCK = (`DTF_DQSCK_MAX_PS + `DTF_TCK_PS - 1) / `DTF_TCK_PS;
    localparam int RPST_NCK = `DTF_RPST_PS / `DTF_TCK_PS;
    localparam int RTW_OFF = `DTF_RL + DQSCK_NCK + `DTF_BL / 2 - `DTF_WL
        + `DTF_WPRE_NCK + RPST_NCK;
    localparam int RTW_ON = `DTF_RL + DQSCK_NCK + `DTF_BL / 2 + RPST_NCK
        - `DTF_TERMINATION_ON_LATENCY_NCK - `DTF_ODTON_MIN_PS / `DTF_TCK_PS + 1;
    dtf_if dtf_if_inst ();
    dtf_ctrl dtf_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lnk(dtf_if_inst));
    dtf_dram dtf_dram_inst (.mclk(mclk), .rst_n(rst_n), .lnk(dtf_if_inst), .wr_inv_en(1'b0),
        .rd_inv_en(1'b0), .mask_en(mask_en), .fifo_wr_ptr(fifo_wr_ptr),
        .fifo_rd_ptr(fifo_rd_ptr), .in_self_refresh());
    dtf_sva #(.RL(`DTF_RL)) dtf_sva_inst (.mclk(mclk), .rst_n(rst_n), .cmd(dtf_if_inst.cmd),
        .op(dtf_if_inst.op), .d_dq_oe(dtf_if_inst.d_dq_oe), .d_dmi_oe(dtf_if_inst.d_dmi_oe));
    // Clock at 20 MHz
    always #25 mclk = ~mclk;
    // Remember any mask pin drive from the device
    always @(posedge mclk)
        if (dtf_if_inst.d_dmi_oe === 1'b1)
            seen_dmi <= 1'b1;
    // Cycles between second halves of paired commands, for turn-around checks
    always @(posedge mclk)
        if (dtf_if_inst.cmd == DTF_CMD_CAS2)
        begin
            cas_gap <= cyc + 1;
            cyc <= 0;
        end
        else
            cyc <= cyc + 1;
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        r = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
            check("pready", 32'h0, 32'h1);
    endtask
    // Launch a command and poll busy under a bound
    task automatic issue(input logic [2:0] k, input logic [31:0] d);
        int n;
        n = 0;
        apb(1'b1, `DTF_REG_WDATA, d);
        apb(1'b1, `DTF_REG_CMD, {29'h0, k});
        do
        begin
            apb(1'b0, `DTF_REG_STATUS, 32'h0);
            n++;
        end
        while (r[0] !== 1'b0 && n < 200);
        if (n >= 200)
            check("busy", 32'h1, 32'h0);
        repeat (2) @(posedge mclk);
    endtask
    // Read data lands read latency after the command
    task automatic rdata(input logic [31:0] e);
        repeat (`DTF_RL + 4) @(posedge mclk);
        apb(1'b0, `DTF_REG_RDATA, 32'h0);
        check("rdata", r, e);
    endtask
    initial
    begin
        #(20000 * 50);
        $display("[FAIL] watchdog expected done seen hang");
        bad_count++;
        conclude();
    end
    initial
    begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            issue(DTF_K_WRF, 32'hA500_0000 + i);
            // Pointer advances only when the burst lands, write latency later
            repeat (`DTF_WL + 4) @(posedge mclk);
            check("wr_ptr", 32'(fifo_wr_ptr), 32'((i + 1) % 5));
        end
        issue(DTF_K_MRW, 32'h0);
        for (int j = 0; j < 6; j++)
        begin
            issue(DTF_K_RDF, 32'h0);
            rdata((j % 5 == 0) ? 32'hA500_0005 : 32'hA500_0000 + j);
            check("rd_ptr", 32'(fifo_rd_ptr), 32'((j + 1) % 5));
        end
        check("dmi", 32'(seen_dmi), 32'h1);
        issue(DTF_K_RD, 32'h0);
        issue(DTF_K_CAL, 32'h0);
        rdata(32'h0);
        issue(DTF_K_RDF, 32'h0);
        apb(1'b0, `DTF_REG_STATUS, 32'h0);
        check("forbid", {r[31:7], r[6:4], r[3:0] & 4'h2}, 32'h22);
        apb(1'b1, `DTF_REG_STATUS, 32'h6);
        apb(1'b0, `DTF_REG_STATUS, 32'h0);
        check("w1c", 32'(r[2:1]), 32'h0);
        issue(DTF_K_WR, 32'h5A5A_0000);
        issue(DTF_K_WRF, 32'h0);
        apb(1'b0, `DTF_REG_STATUS, 32'h0);
        check("status", r & 32'h76, 32'h0);
        issue(DTF_K_RDF, 32'h0);
        issue(DTF_K_WRF, 32'h0);
        check("rtw_off", 32'(cas_gap), 32'(RTW_OFF));
        apb(1'b1, `DTF_REG_CFG, 32'h1);
        issue(DTF_K_RDF, 32'h0);
        issue(DTF_K_WRF, 32'h0);
        check("rtw_on", 32'(cas_gap), 32'(RTW_ON));
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped", {r[31:1], rerr}, 32'h1);
        conclude();
    end
endmodule
